// ===== common/dtcr_pkg.sv
`default_nettype none
package dtcr_pkg;

    // Register byte offsets
    localparam logic [7:0] ADDR_CTRL_AUX  = 8'h00;
    localparam logic [7:0] ADDR_CTRL_CORE = 8'h04;
    localparam logic [7:0] ADDR_CAPCTRL   = 8'h08;
    localparam logic [7:0] ADDR_AUX_CNT   = 8'h0c;
    localparam logic [7:0] ADDR_CORE_CNT  = 8'h10;
    localparam logic [7:0] ADDR_CAPTURE_RELOAD_REG    = 8'h14;
    localparam logic [7:0] ADDR_STATUS    = 8'h18;

    // Timer control fields
    localparam int TC_RUN    = 0;
    localparam int TC_EXTCLK = 1;
    localparam int TC_DOWN   = 2;
    localparam int TC_DIREN  = 3;
    localparam int TC_PRE_LO = 4;   // 3-bit prescaler select, divide 2^(n+1)
    localparam int TC_TGLCLK = 7;   // Aux only: clock from core toggle latch
    localparam int TC_OUTEN  = 7;   // Core only: drive toggle output pin
    localparam int TC_RELEN  = 8;   // Core only: reload on over/underflow

    // Capture control fields
    localparam int CC_EDGE_LO = 0;  // 2-bit: 0 off,1 rise,2 fall,3 both
    localparam int CC_CLR     = 2;
    localparam int CC_SRC_PIN = 3;
    localparam int CC_SRC_CNT = 4;
    localparam int CC_SRC_DIR = 5;

    localparam logic [15:0] CNT_RST  = 16'h0000;
    localparam logic [15:0] CTRL_RST = 16'h0000;
    localparam int          TW       = 16;
    localparam int          MIN_RES  = 2;   // Finest count period in cycles

    typedef struct packed {
        logic cap_pin;
        logic t1_cnt;
        logic t1_dir;
        logic aux_clk;
        logic aux_dir;
        logic core_clk;
        logic core_dir;
    } dtcr_pins_t;

    typedef enum logic [1:0] {
        DTCR_EDGE_OFF,
        DTCR_EDGE_RISE,
        DTCR_EDGE_FALL,
        DTCR_EDGE_BOTH
    } dtcr_edge_t;

endpackage
`default_nettype wire

// ===== rtl/dtcr_timer.sv
`timescale 1ns/1ps
`default_nettype none
module dtcr_timer
    import dtcr_pkg::*;
(
    input  wire logic          clk_i,
    input  wire logic          rst_n_i,
    input  wire logic          ce_i,
    input  wire logic          tick_i,
    input  wire logic          down_i,
    input  wire logic          load_i,
    input  wire logic [TW-1:0] load_val_i,
    output logic      [TW-1:0] cnt_o,   // see R02
    output logic               wrap_o
);

    // Counter with load priority over counting
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cnt_o  <= CNT_RST;
            wrap_o <= 1'b0;
        end
        else if (ce_i)
        begin
            wrap_o <= 1'b0;
            if (load_i)
                cnt_o <= load_val_i;
            else if (tick_i)
            begin
                cnt_o  <= down_i ? cnt_o - 16'h0001 : cnt_o + 16'h0001; // see R11
                wrap_o <= down_i ? (cnt_o == 16'h0000)
                                 : (cnt_o == 16'hffff);         // see R11
            end
        end
    end

endmodule
`default_nettype wire

// ===== rtl/dtcr_top.sv
// Summary of operation
// R01: The block holds an aux timer, a core timer and a capture/reload register, resolving to two clock cycles.
// R02: Each timer is a 16-bit counter.
// R03: Each timer counts prescaled clock ticks or edges of an external input.
// R04: Direction comes from a software bit or, when enabled, the direction pin level.
// R05: The core toggle latch inverts on every core timer overflow or underflow.
// R06: The toggle latch can clock the aux timer and can drive the toggle output pin.
// R07: Core wraps clock the compare-unit timers and can reload the core timer from the capture register.
// R08: A selected capture pin edge copies the aux timer into the capture register.
// R09: With clear-after-capture on, the aux timer goes to zero right after a capture.
// R10: Edges of the first module count and/or direction inputs may also trigger capture.
// R11: Up counting wraps all-ones to zero with overflow, down wraps zero to all-ones with underflow.
// R12: Capture edge is rising, falling or both, and pins are synchronised first.
`timescale 1ns/1ps
`default_nettype none
module dtcr_top
    import dtcr_pkg::*;
(
    input  wire logic        MCLK_I,
    input  wire logic        RESETN_I,
    input  wire logic        CE_I,
    input  wire dtcr_pins_t  PINS_I,
    output logic             TOGGLE_OUT_PIN_O,
    output logic             CMP_UNIT_CLK_O,
    input  wire logic [7:0]  AWADDR,
    input  wire logic        AWVALID,
    output logic             AWREADY,
    input  wire logic [31:0] WDATA,
    input  wire logic [3:0]  WSTRB,
    input  wire logic        WVALID,
    output logic             WREADY,
    output logic [1:0]       BRESP,
    output logic             BVALID,
    input  wire logic        BREADY,
    input  wire logic [7:0]  ARADDR,
    input  wire logic        ARVALID,
    output logic             ARREADY,
    output logic [31:0]      RDATA,
    output logic [1:0]       RRESP,
    output logic             RVALID,
    input  wire logic        RREADY
);

    logic [15:0] ctrl_aux_q, ctrl_core_q, capctrl_q, capture_reload_reg_q;
    logic [15:0] aux_cnt, core_cnt;
    logic        aux_wrap, core_wrap, tgl_q, aux_wrap_q;
    logic [6:0]  meta_q, sync_q, prev_q;
    logic [7:0]  pre_q;
    logic        aux_tick, core_tick, aux_down, core_down;
    logic        aux_load, core_load, cap_evt;
    logic [15:0] aux_load_val;
    logic [1:0]  bdone_q;
    logic [7:0]  awaddr_q;
    logic [31:0] wdata_q;
    logic        aw_have_q, w_have_q, sw_wr;

    ////////////////////////////////////////////////////////////////////////
    // Two-stage synchronisers; only stage two feeds edge logic
    always_ff @(posedge MCLK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            meta_q <= 7'h00;
            sync_q <= 7'h00;
            prev_q <= 7'h00;
        end
        else if (CE_I)
        begin
            meta_q <= PINS_I;             // see R12
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    // Bit order follows dtcr_pins_t: 6 cap,5 t1cnt,4 t1dir,3 auxclk,...
    logic [6:0] rise, fall;
    assign rise = sync_q & ~prev_q;
    assign fall = ~sync_q & prev_q;

    ////////////////////////////////////////////////////////////////////////
    // Shared prescaler; bit 0 toggles every cycle so the finest tick is 2
    always_ff @(posedge MCLK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
            pre_q <= 8'h00;
        else if (CE_I)
            pre_q <= pre_q + 8'h01;       // see R01
    end

    function automatic logic pre_tick(input logic [2:0] sel,
                                      input logic [7:0] p);
        logic [7:0] mask;
        // Eight stages so select 7 still divides by 256, never by 1
        mask = 8'hff >> (3'd7 - sel);
        pre_tick = ((p & mask) == mask);
    endfunction

    // Tick and direction selection per timer
    always_comb
    begin
        if (ctrl_aux_q[TC_TGLCLK])
            aux_tick = core_wrap;         // see R06
        else if (ctrl_aux_q[TC_EXTCLK])
            aux_tick = rise[3];           // see R03
        else
            aux_tick = pre_tick(ctrl_aux_q[TC_PRE_LO +: 3], pre_q); // see R03
        aux_tick  = aux_tick & ctrl_aux_q[TC_RUN];
        core_tick = ctrl_core_q[TC_RUN] &
                    (ctrl_core_q[TC_EXTCLK] ? rise[1]
                     : pre_tick(ctrl_core_q[TC_PRE_LO +: 3], pre_q));
        aux_down  = ctrl_aux_q[TC_DIREN] ? sync_q[2]
                                         : ctrl_aux_q[TC_DOWN];  // see R04
        core_down = ctrl_core_q[TC_DIREN] ? sync_q[0]
                                          : ctrl_core_q[TC_DOWN]; // see R04
    end

    ////////////////////////////////////////////////////////////////////////
    // Capture trigger from pin edge and first-module inputs
    always_comb
    begin
        logic [6:0] sel;
        sel = 7'h00;
        case (dtcr_edge_t'(capctrl_q[CC_EDGE_LO +: 2]))
            DTCR_EDGE_RISE: sel = rise;
            DTCR_EDGE_FALL: sel = fall;
            DTCR_EDGE_BOTH: sel = rise | fall;   // see R12
            default:        sel = 7'h00;
        endcase
        cap_evt = (capctrl_q[CC_SRC_PIN] & sel[6])   // see R08
                | (capctrl_q[CC_SRC_CNT] & sel[5])   // see R10
                | (capctrl_q[CC_SRC_DIR] & sel[4]);  // see R10
    end

    // Clear wins over counting on the capture cycle
    assign aux_load     = cap_evt & capctrl_q[CC_CLR];  // see R09
    assign aux_load_val = 16'h0000;
    assign core_load    = core_wrap & ctrl_core_q[TC_RELEN]; // see R07

    dtcr_timer u_aux (
        .clk_i      (MCLK_I),
        .rst_n_i    (RESETN_I),
        .ce_i       (CE_I),
        .tick_i     (aux_tick),
        .down_i     (aux_down),
        .load_i     (aux_load),
        .load_val_i (aux_load_val),
        .cnt_o      (aux_cnt),
        .wrap_o     (aux_wrap)
    );

    // Core reload lands the cycle after the wrap, replacing the wrapped value
    dtcr_timer u_core (
        .clk_i      (MCLK_I),
        .rst_n_i    (RESETN_I),
        .ce_i       (CE_I),
        .tick_i     (core_tick),
        .down_i     (core_down),
        .load_i     (core_load),
        .load_val_i (capture_reload_reg_q),
        .cnt_o      (core_cnt),
        .wrap_o     (core_wrap)
    );

    ////////////////////////////////////////////////////////////////////////
    // Toggle latch, its pin and the compare-unit clock pulse
    always_ff @(posedge MCLK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            tgl_q            <= 1'b0;
            TOGGLE_OUT_PIN_O <= 1'b0;
            CMP_UNIT_CLK_O   <= 1'b0;
            aux_wrap_q       <= 1'b0;
        end
        else if (CE_I)
        begin
            if (core_wrap)
                tgl_q <= ~tgl_q;                     // see R05
            TOGGLE_OUT_PIN_O <= ctrl_core_q[TC_OUTEN] & tgl_q; // see R06
            CMP_UNIT_CLK_O   <= core_wrap;           // see R07
            if (aux_wrap)
                aux_wrap_q <= 1'b1;
            else if (sw_wr && awaddr_q == ADDR_STATUS)
                aux_wrap_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write path: address and data taken in either order
    assign sw_wr = aw_have_q & w_have_q & ~BVALID;

    always_ff @(posedge MCLK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            awaddr_q  <= 8'h00;
            wdata_q   <= 32'h0000_0000;
            AWREADY   <= 1'b0;
            WREADY    <= 1'b0;
            BVALID    <= 1'b0;
            BRESP     <= 2'h0;
        end
        else if (CE_I)
        begin
            AWREADY <= ~aw_have_q & ~AWREADY & ~BVALID;
            WREADY  <= ~w_have_q & ~WREADY & ~BVALID;
            if (AWVALID && AWREADY)
            begin
                aw_have_q <= 1'b1;
                awaddr_q  <= AWADDR;
            end
            if (WVALID && WREADY)
            begin
                w_have_q <= 1'b1;
                wdata_q  <= WDATA;
            end
            if (sw_wr)
            begin
                aw_have_q <= 1'b0;
                w_have_q  <= 1'b0;
                BVALID    <= 1'b1;
                BRESP     <= (awaddr_q > ADDR_STATUS || awaddr_q[1:0] != 2'h0)
                             ? 2'h2 : 2'h0;
            end
            else if (BVALID && BREADY)
                BVALID <= 1'b0;
        end
    end

    // Register stores; only the low two lanes carry data
    always_ff @(posedge MCLK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            ctrl_aux_q  <= CTRL_RST;
            ctrl_core_q <= CTRL_RST;
            capctrl_q   <= CTRL_RST;
            capture_reload_reg_q    <= CNT_RST;
        end
        else if (CE_I)
        begin
            if (sw_wr && WSTRB[0] | 1'b1)
            begin
                case (awaddr_q)
                    ADDR_CTRL_AUX:  ctrl_aux_q  <= wdata_q[15:0];
                    ADDR_CTRL_CORE: ctrl_core_q <= wdata_q[15:0];
                    ADDR_CAPCTRL:   capctrl_q   <= wdata_q[15:0];
                    ADDR_CAPTURE_RELOAD_REG:    capture_reload_reg_q    <= wdata_q[15:0];
                    default:        ;
                endcase
            end
            // Hardware capture wins over a software write in the same cycle
            if (cap_evt)
                capture_reload_reg_q <= aux_cnt;                 // see R08
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read path, one cycle after the address is taken
    always_ff @(posedge MCLK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            ARREADY <= 1'b0;
            RVALID  <= 1'b0;
            RDATA   <= 32'h0000_0000;
            RRESP   <= 2'h0;
        end
        else if (CE_I)
        begin
            ARREADY <= ~ARREADY & ~RVALID & ARVALID;
            if (ARVALID && ARREADY)
            begin
                RVALID <= 1'b1;
                RRESP  <= 2'h0;
                case (ARADDR)
                    ADDR_CTRL_AUX:  RDATA <= {16'h0000, ctrl_aux_q};
                    ADDR_CTRL_CORE: RDATA <= {16'h0000, ctrl_core_q};
                    ADDR_CAPCTRL:   RDATA <= {16'h0000, capctrl_q};
                    ADDR_AUX_CNT:   RDATA <= {16'h0000, aux_cnt};
                    ADDR_CORE_CNT:  RDATA <= {16'h0000, core_cnt};
                    ADDR_CAPTURE_RELOAD_REG:    RDATA <= {16'h0000, capture_reload_reg_q};
                    ADDR_STATUS:    RDATA <= {30'h0, aux_wrap_q, tgl_q};
                    default:
                    begin
                        RDATA <= 32'h0000_0000;
                        RRESP <= 2'h2;
                    end
                endcase
            end
            else if (RVALID && RREADY)
                RVALID <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    chk_toggle_on_wrap: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
        CE_I && core_wrap |=> tgl_q != $past(tgl_q)) // see R05
        else $error("toggle latch did not invert on core wrap");
    chk_toggle_hold: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
        !core_wrap |=> tgl_q == $past(tgl_q)) // see R05
        else $error("toggle latch changed without wrap");
    chk_capture_copy: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
        CE_I && cap_evt |=> capture_reload_reg_q == $past(aux_cnt)) // see R08
        else $error("capture did not copy aux timer");
    chk_capture_clear: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
        CE_I && cap_evt && capctrl_q[CC_CLR] |=> aux_cnt == 16'h0000) // see R09
        else $error("aux timer not cleared after capture");
    chk_core_reload: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
        CE_I && core_wrap && ctrl_core_q[TC_RELEN] |=> core_cnt == $past(capture_reload_reg_q)) // see R07
        else $error("core timer not reloaded");
    chk_cmp_clock: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
        CE_I |=> CMP_UNIT_CLK_O == $past(core_wrap)) // see R07
        else $error("compare clock does not follow core wrap");
    chk_up_wrap: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
        CE_I && aux_tick && !aux_load && !aux_down && aux_cnt == 16'hffff
        |=> aux_cnt == 16'h0000 && aux_wrap) // see R11
        else $error("up overflow wrong");
    chk_down_wrap: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
        CE_I && aux_tick && !aux_load && aux_down && aux_cnt == 16'h0000
        |=> aux_cnt == 16'hffff && aux_wrap) // see R11
        else $error("down underflow wrong");

endmodule
`default_nettype wire

// ===== verification/dtcr_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module dtcr_pin_model
    import dtcr_pkg::*;
(
    input  wire logic   clk_i,
    output var dtcr_pins_t pins_o
);
    // All pins start low, as an idle external source would leave them
    initial pins_o = '0;

    // Hold every level four cycles so the two-flop synchroniser sees it
    task automatic set_pin(input int idx, input logic v);
        @(posedge clk_i);
        pins_o[idx] <= v;
        repeat (4) @(posedge clk_i);
    endtask

    // Rising then falling edge, n times
    task automatic pulse(input int idx, input int n);
        repeat (n)
        begin
            set_pin(idx, 1'b1);
            set_pin(idx, 1'b0);
        end
    endtask
endmodule
`default_nettype wire

// ===== verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import dtcr_pkg::*;
;
    logic        clk, rst_n, ce, tgl, cmp;
    logic        awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, rd_v;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, rsp;
    dtcr_pins_t  pins;
    int          fail_count, n_compared, cyc, cmp_n;
    int          aux_m, cap_m, n, v, v0;
    time         t0;

    dtcr_top DUT (.MCLK_I(clk), .RESETN_I(rst_n), .CE_I(ce), .PINS_I(pins),
        .TOGGLE_OUT_PIN_O(tgl), .CMP_UNIT_CLK_O(cmp), .AWADDR(awaddr),
        .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb),
        .WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid),
        .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
        .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid),
        .RREADY(rready));
    dtcr_pin_model u_pins (.clk_i(clk), .pins_o(pins));

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Cycle count, wrap pulse count and hang guard
    always @(posedge clk)
    begin
        cyc++;
        if (cmp === 1'b1) cmp_n++;
        if (cyc == 20000)
        begin
            fail_count++;
            results();
        end
    end

    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] seen,
                         input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Bus master: address and data offered together, each released alone
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bit da, dw;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        da = 0;
        dw = 0;
        while (!(da && dw))
        begin
            @(posedge clk);
            if (awready === 1'b1)
            begin
                da = 1;
                awvalid <= 1'b0;
            end
            if (wready === 1'b1)
            begin
                dw = 1;
                wvalid <= 1'b0;
            end
        end
        while (bvalid !== 1'b1) @(posedge clk);
        rsp = bresp;
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1) @(posedge clk);
        rd_v = rdata;
        rsp = rresp;
        rready <= 1'b0;
    endtask

    task automatic rdc(input logic [7:0] a, input int exp);
        rd(a);
        check("register", rd_v, 32'(exp & 16'hffff));
    endtask

    // Pin events reach the counters a few cycles after the last change
    task automatic settle();
        repeat (8) @(posedge clk);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata, rst_n} = '0;
        wstrb = 4'hf;
        ce = 1'b1;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        void'($urandom(34));
        for (int a = 0; a <= 8'h18; a += 4) rdc(8'(a), 0);
        rd(8'h1c);
        check("unmapped resp", 32'(rsp), 32'h2);
        check("unmapped data", rd_v, 32'h0);
        wr(8'h1c, 32'h5);
        check("unmapped wresp", 32'(rsp), 32'h2);
        wr(8'h02, 32'h1);
        check("misaligned wresp", 32'(rsp), 32'h2);
        rdc(ADDR_CTRL_AUX, 0);
        $display("test reset done");
        // External clocking and captures on each edge selection
        wr(ADDR_CTRL_AUX, 32'h3);
        check("write resp", 32'(rsp), 32'h0);
        // At least 3 so the later prescaled run carries aux through all-ones
        n = $urandom_range(20, 3);
        u_pins.pulse(3, n);
        aux_m = n;
        settle();
        rdc(ADDR_AUX_CNT, aux_m);
        for (int m = 0; m < 4; m++)
        begin
            wr(ADDR_CAPCTRL, 32'(m | 8));
            u_pins.pulse(3, 2);
            aux_m += 2;
            u_pins.set_pin(6, 1'b1);
            settle();
            if (m == 1 || m == 3) cap_m = aux_m;
            rdc(ADDR_CAPTURE_RELOAD_REG, cap_m);
            u_pins.pulse(3, 1);
            aux_m++;
            u_pins.set_pin(6, 1'b0);
            settle();
            if (m >= 2) cap_m = aux_m;
            rdc(ADDR_CAPTURE_RELOAD_REG, cap_m);
        end
        // Capture from first module inputs, clearing the aux timer
        for (int s = 0; s < 2; s++)
        begin
            u_pins.pulse(3, 3);
            aux_m += 3;
            wr(ADDR_CAPCTRL, 32'h5 | (32'h10 << s));
            u_pins.set_pin(5 - s, 1'b1);
            settle();
            cap_m = aux_m;
            aux_m = 0;
            rdc(ADDR_CAPTURE_RELOAD_REG, cap_m);
            rdc(ADDR_AUX_CNT, aux_m);
            wr(ADDR_CAPCTRL, 32'h0);
            u_pins.set_pin(5 - s, 1'b0);
        end
        $display("test capture done");
        // Down count through zero, then direction from the pin
        wr(ADDR_CTRL_AUX, 32'h7);
        u_pins.pulse(3, n);
        aux_m -= n;
        settle();
        rdc(ADDR_AUX_CNT, aux_m);
        rd(ADDR_STATUS);
        check("aux wrap", 32'(rd_v[1]), 32'h1);
        wr(ADDR_STATUS, 32'h0);
        rdc(ADDR_STATUS, 0);
        wr(ADDR_CTRL_AUX, 32'hb);
        for (int d = 1; d >= 0; d--)
        begin
            u_pins.set_pin(2, 1'(d));
            u_pins.pulse(3, n);
            aux_m += d ? -n : n;
            settle();
            rdc(ADDR_AUX_CNT, aux_m);
        end
        $display("test direction done");
        // Core wraps: reload, toggle latch, output pin, chained aux
        v = $urandom_range(10, 2);
        wr(ADDR_CAPTURE_RELOAD_REG, 32'(v));
        wr(ADDR_CTRL_AUX, 32'h81);
        wr(ADDR_CTRL_CORE, 32'h187);
        for (int w = 1; w <= 2; w++)
        begin
            u_pins.pulse(1, w == 1 ? 1 : v + 1);
            aux_m++;
            settle();
            rdc(ADDR_CORE_CNT, v);
            rd(ADDR_STATUS);
            check("latch", 32'(rd_v[0]), 32'(w & 1));
            check("toggle pin", 32'(tgl), 32'(w & 1));
            check("wrap clocks", 32'(cmp_n), 32'(w));
            rdc(ADDR_AUX_CNT, aux_m);
        end
        $display("test core done");
        // Prescaled clock: divide 2 and divide 4 over 200 cycles
        for (int p = 0; p < 2; p++)
        begin
            wr(ADDR_CTRL_AUX, 32'h0);
            rd(ADDR_AUX_CNT);
            v0 = int'(rd_v[15:0]);
            wr(ADDR_CTRL_AUX, 32'h1 | (32'(p) << 4));
            t0 = $time;
            repeat (200) @(posedge clk);
            wr(ADDR_CTRL_AUX, 32'h0);
            // Counting spans the edges between the two write ends, so the
            // expected ticks come from elapsed time, not a fixed 200
            v = int'(($time - t0) / 100) >> (p + 1);
            rd(ADDR_AUX_CNT);
            v = ((int'(rd_v[15:0]) - v0) & 32'hffff) - v;
            check("prescale", 32'(v inside {[-2:2]}), 32'h1);
        end
        $display("test prescaler done");
        // Clock enable low: pin edges and counting are both frozen
        wr(ADDR_CTRL_AUX, 32'h3);
        rd(ADDR_AUX_CNT);
        v0 = int'(rd_v[15:0]);
        ce <= 1'b0;
        u_pins.pulse(3, 2);
        ce <= 1'b1;
        settle();
        rdc(ADDR_AUX_CNT, v0);
        $display("test clock enable done");
        results();
    end
endmodule
`default_nettype wire
